// ---- hdl/oscdec_defs.svh ----
// constants for the oscillator configuration word decoder
`ifndef OSCDEC_DEFS_SVH
`define OSCDEC_DEFS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------
`define OSCDEC_OFS_CFG_WORD     12'h000
`define OSCDEC_OFS_STATUS       12'h004
`define OSCDEC_OFS_RELOAD       12'h008
// ----------------------------------------------------------------
// field positions in the configuration word
// ----------------------------------------------------------------
`define OSCDEC_BIT_FSCM         15
`define OSCDEC_BIT_SWITCH       14
`define OSCDEC_BIT_SEC_XTAL     12
`define OSCDEC_BIT_CLKOUT_FN    10
`define OSCDEC_POS_PRI_MODE     8
`define OSCDEC_BIT_TWO_SPEED    7
`define OSCDEC_BIT_SEC_EN       6
`define OSCDEC_BIT_PLL_REF      4
`define OSCDEC_POS_INIT_OSC     0
`define OSCDEC_RSVD_MASK        32'hffff_2828
// ----------------------------------------------------------------
// reset and timing
// ----------------------------------------------------------------
`define OSCDEC_WORD_RESET       32'hffff_ffff
`define OSCDEC_LOAD_WAIT        8'h04
`endif

// ---- hdl/oscdec_pkg.sv ----
// types for the oscillator configuration word decoder
package oscdec_pkg;
  // primary oscillator operating mode
  typedef enum logic [1:0]
  {
    OSCDEC_PRI_EXT_CLK,
    OSCDEC_PRI_STD_XTAL,
    OSCDEC_PRI_HIGH_SPEED_XTAL,
    OSCDEC_PRI_OFF
  } oscdec_pri_mode_t;
  // initial oscillator choice after decode
  typedef enum logic [2:0]
  {
    OSCDEC_INIT_FAST_RC_DIV,
    OSCDEC_INIT_PRI_OR_FAST_RC_PLL,
    OSCDEC_INIT_PRI,
    OSCDEC_INIT_SEC,
    OSCDEC_INIT_LOW_POWER_RC
  } oscdec_init_osc_t;
endpackage : oscdec_pkg

// ---- hdl/oscdec_cfg_if.sv ----
// interface carrying the captured word between loader and decoder
`timescale 1ns/1ps
interface oscdec_cfg_if;
  logic [31:0] word;   // captured configuration word
  logic        valid;  // word has been captured
  modport loader (output word, output valid);
  modport user   (input word, input valid);
endinterface : oscdec_cfg_if

// ---- hdl/oscdec_loader.sv ----
// capture of the configuration word from storage after reset
`timescale 1ns/1ps
`include "oscdec_defs.svh"
module oscdec_loader
(
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_b_i,
  // storage side
  input  wire logic [31:0] flash_word_i,
  input  wire logic   reload_i,
  // captured word
  oscdec_cfg_if.loader cfg
);
  // ----------------------------------------------------------------
  // settle counter, then a single capture
  // ----------------------------------------------------------------
  logic [7:0] wait_reg;   // cycles left before capture
  logic       done_reg;   // capture done
  logic [31:0] word_reg;  // held word

  // wait for storage to settle after reset release
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wait_reg <= `OSCDEC_LOAD_WAIT;
    else if (reload_i)
      wait_reg <= `OSCDEC_LOAD_WAIT;
    else if (wait_reg != 8'h00)
      wait_reg <= wait_reg - 8'h01;
  end

  // capture once, hold until next reset or reload
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      done_reg <= 1'b0;
      word_reg <= `OSCDEC_WORD_RESET;
    end
    else if (reload_i)
      done_reg <= 1'b0;
    else if (!done_reg && wait_reg == 8'h00)
    begin
      done_reg <= 1'b1;
      word_reg <= flash_word_i;
    end
  end

  assign cfg.word  = word_reg;
  assign cfg.valid = done_reg;
endmodule : oscdec_loader

// ---- hdl/oscdec_top.sv ----
// oscillator configuration word decoder with register access
//
// Summary of operation
// - switching allowed only when bit 14 set
// - fail-safe monitor only when bit 15 set
// - crystal secondary owns its two shared pins
// - external secondary clock, pins stay with ports
// - clock-out pin drives sysclk when bit clear
// - primary mode: off, fast, standard, external clock
// - two-speed start-up only when bit set
// - secondary oscillator enabled by its bit
// - PLL reference fast RC or primary at reset
// - initial oscillator decode, reserved falls to fast RC
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "oscdec_defs.svh"
module oscdec_top
(
  // clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  // configuration storage
  input  wire logic [31:0] FLASH_WORD_I,
  // axi4-lite write address
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [11:0] S_AXI_AWADDR,
  // axi4-lite write data
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  // axi4-lite write response
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  // axi4-lite read address
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  // axi4-lite read data
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  // decoded clock settings
  output logic             SETTINGS_VALID_O,
  output logic             CLOCK_SWITCH_EN_O,
  output logic             FAIL_SAFE_MON_EN_O,
  output logic             SEC_XTAL_PINS_O,
  output logic             SEC_EXT_CLK_O,
  output logic             CLOCK_OUT_PIN_SYSCLK_O,
  output oscdec_pkg::oscdec_pri_mode_t PRI_MODE_O,
  output logic             TWO_SPEED_STARTUP_O,
  output logic             SEC_OSC_EN_O,
  output logic             PLL_REF_FAST_RC_O,
  output oscdec_pkg::oscdec_init_osc_t INIT_OSC_O,
  output logic             RSVD_ERROR_O
);
  import oscdec_pkg::*;

  // ----------------------------------------------------------------
  // word capture
  // ----------------------------------------------------------------
  oscdec_cfg_if cfg_bus ();   // captured word carrier
  logic         reload_pulse; // software request to recapture

  // samples the storage word once after reset and again after each reload
  oscdec_loader u_loader
  (
    .clk_i        (CORE_CLK_I),
    .rst_b_i      (RST_B_I),
    .flash_word_i (FLASH_WORD_I),
    .reload_i     (reload_pulse),
    .cfg          (cfg_bus.loader)
  );

  // ----------------------------------------------------------------
  // decode into held settings
  // ----------------------------------------------------------------
  logic [31:0] w;            // captured word
  logic [2:0]  init_field;   // initial oscillator field
  logic        valid_reg;    // settings latched

  assign w          = cfg_bus.word;
  assign init_field = w[`OSCDEC_POS_INIT_OSC +: 3];

  // settings follow the held word only
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      valid_reg              <= 1'b0;
      CLOCK_SWITCH_EN_O      <= 1'b0;
      FAIL_SAFE_MON_EN_O     <= 1'b0;
      SEC_XTAL_PINS_O        <= 1'b0;
      SEC_EXT_CLK_O          <= 1'b0;
      CLOCK_OUT_PIN_SYSCLK_O <= 1'b0;
      PRI_MODE_O             <= OSCDEC_PRI_OFF;
      TWO_SPEED_STARTUP_O    <= 1'b0;
      SEC_OSC_EN_O           <= 1'b0;
      PLL_REF_FAST_RC_O      <= 1'b1;
      RSVD_ERROR_O           <= 1'b0;
    end
    else
    begin
      valid_reg              <= cfg_bus.valid;
      CLOCK_SWITCH_EN_O      <= w[`OSCDEC_BIT_SWITCH];
      FAIL_SAFE_MON_EN_O     <= w[`OSCDEC_BIT_FSCM];
      SEC_XTAL_PINS_O        <= w[`OSCDEC_BIT_SEC_XTAL];
      SEC_EXT_CLK_O          <= !w[`OSCDEC_BIT_SEC_XTAL];
      CLOCK_OUT_PIN_SYSCLK_O <= !w[`OSCDEC_BIT_CLKOUT_FN];
      // field encoding matches enum order directly
      PRI_MODE_O <= oscdec_pri_mode_t'(w[`OSCDEC_POS_PRI_MODE +: 2]);
      TWO_SPEED_STARTUP_O    <= w[`OSCDEC_BIT_TWO_SPEED];
      SEC_OSC_EN_O           <= w[`OSCDEC_BIT_SEC_EN];
      PLL_REF_FAST_RC_O      <= w[`OSCDEC_BIT_PLL_REF];
      // flag a word whose reserved bits are not all one
      RSVD_ERROR_O <= (w & `OSCDEC_RSVD_MASK) != `OSCDEC_RSVD_MASK;
    end
  end

  // initial oscillator decode, reserved codes fall back to fast rc
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      INIT_OSC_O <= OSCDEC_INIT_FAST_RC_DIV;
    else
    begin
      case (init_field)
        3'h1:    INIT_OSC_O <= OSCDEC_INIT_PRI_OR_FAST_RC_PLL;
        3'h2:    INIT_OSC_O <= OSCDEC_INIT_PRI;
        3'h4:    INIT_OSC_O <= OSCDEC_INIT_SEC;
        3'h5:    INIT_OSC_O <= OSCDEC_INIT_LOW_POWER_RC;
        default: INIT_OSC_O <= OSCDEC_INIT_FAST_RC_DIV;
      endcase
    end
  end

  assign SETTINGS_VALID_O = valid_reg;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic        aw_got_reg;  // write address held
  logic        w_got_reg;   // write data held
  logic [11:0] aw_addr_reg; // held write address
  logic [31:0] w_data_reg;  // held write data
  logic        w_strb0_reg; // low byte lane enabled
  logic        wr_fire;     // both halves present

  assign S_AXI_AWREADY = !aw_got_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_got_reg && !S_AXI_BVALID;
  assign wr_fire       = aw_got_reg && w_got_reg;

  // collect address and data in either order
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_got_reg   <= 1'b1;
        w_data_reg  <= S_AXI_WDATA;
        w_strb0_reg <= S_AXI_WSTRB[0];
      end
    end
  end

  // only the reload register accepts writes
  assign reload_pulse = wr_fire && w_strb0_reg && w_data_reg[0]
                        && aw_addr_reg[11:2] == `OSCDEC_OFS_RELOAD >> 2;

  // write response, slverr for anything but the reload register
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'b00;
    end
    else if (wr_fire)
    begin
      S_AXI_BVALID <= 1'b1;
      if (aw_addr_reg[11:2] == `OSCDEC_OFS_RELOAD >> 2)
        S_AXI_BRESP <= 2'b00;
      else
        S_AXI_BRESP <= 2'b10;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [31:0] status_word; // decoded settings readback

  assign S_AXI_ARREADY = !S_AXI_RVALID;
  // bits 31:17 read as zero, valid flag sits at bit 16
  assign status_word   = {15'h0000, valid_reg, RSVD_ERROR_O, 3'h0,
                          INIT_OSC_O, PRI_MODE_O, CLOCK_SWITCH_EN_O,
                          FAIL_SAFE_MON_EN_O, SEC_XTAL_PINS_O,
                          CLOCK_OUT_PIN_SYSCLK_O, TWO_SPEED_STARTUP_O,
                          SEC_OSC_EN_O, PLL_REF_FAST_RC_O};

  // one read at a time, answer the cycle after the address
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= 2'b00;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= 2'b00;
      if (S_AXI_ARADDR[11:2] == `OSCDEC_OFS_CFG_WORD >> 2)
        S_AXI_RDATA <= w;
      else if (S_AXI_ARADDR[11:2] == `OSCDEC_OFS_STATUS >> 2)
        S_AXI_RDATA <= status_word;
      else if (S_AXI_ARADDR[11:2] == `OSCDEC_OFS_RELOAD >> 2)
        S_AXI_RDATA <= 32'h0000_0000;
      else
      begin
        S_AXI_RDATA <= 32'h0000_0000;
        S_AXI_RRESP <= 2'b10;
      end
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end
endmodule : oscdec_top

// ---- dv/oscdec_top_asserts.sv ----
// concurrent checks on the decoder's settings outputs
`timescale 1ns/1ps
`include "oscdec_defs.svh"
module oscdec_top_asserts
(
  // clock, reset and stored word
  input wire logic        CORE_CLK_I,
  input wire logic        RST_B_I,
  input wire logic [31:0] FLASH_WORD_I,
  // decoded settings
  input wire logic        SETTINGS_VALID_O,
  input wire logic        CLOCK_SWITCH_EN_O,
  input wire logic        FAIL_SAFE_MON_EN_O,
  input wire logic        SEC_XTAL_PINS_O,
  input wire logic        SEC_EXT_CLK_O,
  input wire logic        CLOCK_OUT_PIN_SYSCLK_O,
  input wire oscdec_pkg::oscdec_pri_mode_t PRI_MODE_O,
  input wire logic        TWO_SPEED_STARTUP_O,
  input wire logic        SEC_OSC_EN_O,
  input wire logic        PLL_REF_FAST_RC_O,
  input wire oscdec_pkg::oscdec_init_osc_t INIT_OSC_O,
  input wire logic        RSVD_ERROR_O
);
  import oscdec_pkg::*;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic [31:0] w;  // stored word, held stable across capture
  assign w = FLASH_WORD_I;
  // decoded settings have just appeared
  sequence cap;
    $rose(SETTINGS_VALID_O);
  endsequence
  // settings valid on this edge and the one before
  sequence settled;
    SETTINGS_VALID_O && $past(SETTINGS_VALID_O);
  endsequence
  sw_en_a: assert property (cap |-> CLOCK_SWITCH_EN_O == w[14])
    else $error("switch enable wrong");
  fail_mon_a: assert property (cap |-> FAIL_SAFE_MON_EN_O == w[15])
    else $error("fail-safe monitor wrong");
  sec_pins_a: assert property (cap |-> SEC_XTAL_PINS_O == w[12]
    && SEC_EXT_CLK_O == !w[12]) else $error("secondary pins wrong");
  clk_out_a: assert property (cap |-> CLOCK_OUT_PIN_SYSCLK_O != w[10])
    else $error("clock-out pin wrong");
  pri_mode_a: assert property (cap |-> PRI_MODE_O == w[9:8])
    else $error("primary mode wrong");
  bits_set_a: assert property (cap |-> TWO_SPEED_STARTUP_O == w[7]
    && SEC_OSC_EN_O == w[6] && PLL_REF_FAST_RC_O == w[4])
    else $error("single-bit setting wrong");
  init_osc_a: assert property (cap |-> INIT_OSC_O == ((w[2:0] == 3'h4) ?
    3'h3 : (w[2:0] == 3'h5) ? 3'h4 : (w[2:0] < 3'h3) ? w[2:0] : 3'h0))
    else $error("initial oscillator wrong");
  rsvd_a: assert property (cap |-> RSVD_ERROR_O ==
    ((w & `OSCDEC_RSVD_MASK) != `OSCDEC_RSVD_MASK)) else $error("reserved flag");
  hold_a: assert property (settled |-> $stable({CLOCK_SWITCH_EN_O,
    FAIL_SAFE_MON_EN_O, SEC_XTAL_PINS_O, PRI_MODE_O, INIT_OSC_O, SEC_OSC_EN_O}))
    else $error("settings moved while valid");
  load_a: assert property ($rose(RST_B_I) |-> !SETTINGS_VALID_O [*3]
    ##[1:5] SETTINGS_VALID_O) else $error("capture after reset late");
endmodule : oscdec_top_asserts
bind oscdec_top oscdec_top_asserts u_chk (.CORE_CLK_I, .RST_B_I, .FLASH_WORD_I,
  .SETTINGS_VALID_O, .CLOCK_SWITCH_EN_O, .FAIL_SAFE_MON_EN_O, .SEC_XTAL_PINS_O,
  .SEC_EXT_CLK_O, .CLOCK_OUT_PIN_SYSCLK_O, .PRI_MODE_O, .TWO_SPEED_STARTUP_O,
  .SEC_OSC_EN_O, .PLL_REF_FAST_RC_O, .INIT_OSC_O, .RSVD_ERROR_O);

// ---- dv/oscdec_flash_model.sv ----
// model of the configuration storage that feeds the stored word
`timescale 1ns/1ps
`include "oscdec_defs.svh"
module oscdec_flash_model
(
  // programming side
  input  wire logic [31:0] prog_i,
  input  wire logic        keep_rsvd_i,
  // stored word
  output logic      [31:0] word_o
);
  // a careful programmer forces every reserved bit to one
  assign word_o = keep_rsvd_i ? (prog_i | `OSCDEC_RSVD_MASK) : prog_i;
endmodule : oscdec_flash_model

// ---- dv/tb_top.sv ----
// self-checking bench for the oscillator configuration word decoder
`timescale 1ns/1ps
`include "oscdec_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic c = 0, rst_b = 0, keep = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [31:0] prog = 32'hffff_ffff, wd = 0, flash, d, w, ew, seed = 32'hcf86;
  logic [11:0] awa = 0, ara = 0;
  logic [1:0]  r;
  logic        awr, wr, bv, arr, rv, vld, ext;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  int          failures = 0, cmp_count = 0;
  always #2.5 c = ~c;
  oscdec_flash_model u_mem (.prog_i(prog), .keep_rsvd_i(keep), .word_o(flash));
  oscdec_top u_dut (.CORE_CLK_I(c), .RST_B_I(rst_b), .FLASH_WORD_I(flash),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .SETTINGS_VALID_O(vld),
    .CLOCK_SWITCH_EN_O(), .FAIL_SAFE_MON_EN_O(), .SEC_XTAL_PINS_O(),
    .SEC_EXT_CLK_O(ext), .CLOCK_OUT_PIN_SYSCLK_O(), .PRI_MODE_O(),
    .TWO_SPEED_STARTUP_O(), .SEC_OSC_EN_O(), .PLL_REF_FAST_RC_O(),
    .INIT_OSC_O(), .RSVD_ERROR_O());
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // status word expected for a captured word
  function automatic logic [31:0] exp_st(input logic [31:0] x);
    logic [2:0] i;
    i = (x[2:0] == 3'h4) ? 3'h3 : (x[2:0] == 3'h5) ? 3'h4 :
        (x[2:0] < 3'h3) ? x[2:0] : 3'h0;
    return {15'h0, 1'b1, (x & `OSCDEC_RSVD_MASK) != `OSCDEC_RSVD_MASK, 3'h0,
            i, x[9:8], x[14], x[15], x[12], ~x[10], x[7], x[6], x[4]};
  endfunction : exp_st
  // write: address and data offered together, released when taken
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw;
    @(posedge c);
    awv <= 1; wv <= 1; awa <= a; wd <= v; bry <= 1;
    // no cycle count assumed: ends when bvalid is seen, only the watchdog bounds this wait
    forever
    begin
      @(negedge c);
      ta = awv & awr; tw = wv & wr;
      if (bv) break;
      @(posedge c);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
    @(posedge c);
    r = br; bry <= 0;
  endtask : axw
  // read: address held until taken, data taken with rvalid
  task automatic axr(input logic [11:0] a);
    logic ta;
    @(posedge c);
    arv <= 1; ara <= a; rry <= 1;
    // no cycle count assumed: ends when rvalid is seen, only the watchdog bounds this wait
    forever
    begin
      @(negedge c);
      ta = arv & arr;
      if (rv) break;
      @(posedge c);
      if (ta) arv <= 0;
    end
    @(posedge c);
    d = rdat; r = rr; rry <= 0;
  endtask : axr
  task automatic wait_vld();
    for (int k = 0; k < 60 && vld !== 1'b1; k++) @(posedge c);
  endtask : wait_vld
  task automatic conclude();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge c);
    rst_b <= 1;
    for (int i = 0; i < 24; i++)
    begin
      w = rnd();
      if (i < 8) w[9:0] = {i[1:0], w[7:3], i[2:0]};  // every init and mode code
      @(posedge c);
      rst_b <= 0; prog <= w; keep <= i[0];
      repeat (2) @(posedge c);
      rst_b <= 1;
      wait_vld();
      ew = i[0] ? (w | `OSCDEC_RSVD_MASK) : w;
      axr(`OSCDEC_OFS_CFG_WORD); `CHK(d, ew)
      axr(`OSCDEC_OFS_STATUS);
      `CHK(d, exp_st(ew))
      `CHK(ext, ~ew[12])
      prog <= ~w;  // storage changes while running
      repeat (8) @(posedge c);
      axr(`OSCDEC_OFS_STATUS); `CHK(d, exp_st(ew))
    end
    axw(`OSCDEC_OFS_RELOAD, 32'h1); `CHK(r, 2'b00)
    repeat (3) @(posedge c);
    wait_vld();
    // storage still forces reserved bits when the last pass asked for it
    ew = keep ? (prog | `OSCDEC_RSVD_MASK) : prog;
    axr(`OSCDEC_OFS_STATUS); `CHK(d, exp_st(ew))
    axw(`OSCDEC_OFS_CFG_WORD, 32'h0); `CHK(r, 2'b10)
    axr(12'h0fc); `CHK({r, d}, 34'h2_0000_0000)
    conclude();
  end
  // watchdog: the whole run needs under a thousand cycles
  initial
  begin
    #200000;
    failures++;
    conclude();
  end
endmodule : tb_top
